// ### verilog/mrs_pkg.sv
/*
 * constants, codes and state types shared by both ends of the frame link
 * assumes nothing beyond a SystemVerilog compiler
 */
`default_nettype none

package mrs_pkg;
	typedef logic [15:0] mrs_word_t;
	typedef logic [16:0] mrs_regnum_t;
	// ----------------------------------------
	// function and exception codes
	// ----------------------------------------
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WR1 = 8'h06;
	localparam logic [7:0] FC_WRN = 8'h10;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VAL = 8'h03;
	localparam logic [7:0] EXC_FAIL = 8'h04;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	// ----------------------------------------
	// check sum, frame layout, register numbering and reset value
	// ----------------------------------------
	localparam mrs_word_t CRC_SEED = 16'hFFFF;
	localparam mrs_word_t CRC_POLY = 16'hA001;
	localparam int CRC_STEPS = 8;
	localparam mrs_regnum_t REG_NUM_BASE = 17'h09C41;
	localparam mrs_word_t REG_RST = 16'h0000;
	localparam int HDR_LEN = 6;
	localparam int WRN_HDR = 7;
	localparam int RD_HDR = 3;
	localparam int EXC_LEN = 3;
	localparam int CRC_LEN = 2;
	localparam int REQ_LEN = 8;
	localparam int MIN_LEN = 4;
	localparam int MAX_RD_CNT = 125;
	localparam int MAX_WR_CNT = 123;
	// ----------------------------------------
	// state machines
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_RX = 4'h1,
		ST_CHK = 4'h2,
		ST_WR = 4'h4,
		ST_TX = 4'h8
	} mrs_dev_st_t;
	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_TX = 4'h2,
		HS_RX = 4'h4,
		HS_END = 4'h8
	} mrs_host_st_t;
endpackage

`default_nettype wire

// ### verilog/mrs_link_if.sv
/*
 * byte stream link between the master end and the slave end
 * assumes both ends share one clock; a byte is valid for one cycle and
 * eof marks the last byte of a frame, standing in for line silence
 */
`default_nettype none

interface mrs_link_if;
	logic [7:0] m2s_data;
	logic m2s_valid;
	logic m2s_eof;
	logic [7:0] s2m_data;
	logic s2m_valid;
	logic s2m_eof;
	modport master (
		output m2s_data, m2s_valid, m2s_eof,
		input s2m_data, s2m_valid, s2m_eof
	);
	modport slave (
		input m2s_data, m2s_valid, m2s_eof,
		output s2m_data, s2m_valid, s2m_eof
	);
endinterface

`default_nettype wire

// ### verilog/mrs_crc.sv
/*
 * check sum accumulator, one whole byte per clock
 * assumes the caller raises init with the first byte of each frame
 */
`default_nettype none

module mrs_crc (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// byte feed
	input wire logic init,
	input wire logic valid,
	input wire logic [7:0] data,
	// running value
	output mrs_pkg::mrs_word_t crc
);
	import mrs_pkg::*;

	mrs_word_t next_crc;

	// only the data byte enters; framing bits never reach this port
	always_comb begin
		next_crc = init ? CRC_SEED : crc;
		if (valid) begin
			next_crc = next_crc ^ {8'h00, data};
			for (int i = 0; i < CRC_STEPS; i++) begin
				next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc <= CRC_SEED;
		end else begin
			crc <= next_crc;
		end
	end
endmodule

`default_nettype wire

// ### verilog/mrs_slave.sv
/*
 * slave end: parses requests, keeps the holding registers, answers
 * assumes the master waits for the answer before the next request;
 * bytes arriving while a request is handled are ignored
 */
`default_nettype none

module mrs_slave #(
	parameter int NREG = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link to the master
	mrs_link_if.slave lnk,
	// station settings
	input wire logic [7:0] own_addr,
	input wire logic dev_fail,
	// register write notice and frame drop pulse
	output logic wr_valid,
	output mrs_pkg::mrs_regnum_t wr_num,
	output mrs_pkg::mrs_word_t wr_data,
	output logic drop
);
	import mrs_pkg::*;

	localparam int MAXB = WRN_HDR + 2 * NREG + CRC_LEN;
	localparam int BW = $clog2(MAXB);
	localparam int RW = $clog2(NREG);

	if (NREG < 2 || NREG > MAX_WR_CNT) begin : g_bad_nreg
		$error("NREG must lie between 2 and 123");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	mrs_dev_st_t state, next_state;
	logic [7:0] rxb [MAXB];
	logic [7:0] next_rxb [MAXB];
	mrs_word_t regs [NREG];
	mrs_word_t next_regs [NREG];
	logic [8:0] cnt, next_cnt;
	logic [7:0] ptr, next_ptr;
	logic [7:0] exc, next_exc;
	logic [7:0] tx_d, next_tx_d;
	logic tx_v, next_tx_v;
	logic tx_e, next_tx_e;
	logic next_wr_valid;
	mrs_regnum_t next_wr_num;
	mrs_word_t next_wr_data;
	logic next_drop;

	// ----------------------------------------
	// working values
	// ----------------------------------------
	logic crc_init, crc_v;
	logic [7:0] crc_d;
	mrs_word_t crc;
	logic [7:0] fc, body, tx_len, j;
	mrs_word_t fa, fn, wdat;
	logic [16:0] fend;
	logic [8:0] wrn_len;
	logic [RW-1:0] ridx, widx;
	logic [BW-1:0] di;
	logic chk_bad;
	logic [7:0] chk_exc;

	assign fc = rxb[1];
	assign fa = {rxb[2], rxb[3]};
	assign fn = {rxb[4], rxb[5]};
	assign fend = {1'b0, fa} + {1'b0, fn};
	assign wrn_len = 9'(WRN_HDR + CRC_LEN) + {1'b0, rxb[6]};
	assign lnk.s2m_data = tx_d;
	assign lnk.s2m_valid = tx_v;
	assign lnk.s2m_eof = tx_e;

	// one engine serves receive and send: the link is half duplex
	mrs_crc u_crc (
		.clk(clk),
		.rst_n(rst_n),
		.init(crc_init),
		.valid(crc_v),
		.data(crc_d),
		.crc(crc)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_rxb = rxb;
		next_regs = regs;
		next_cnt = cnt;
		next_ptr = ptr;
		next_exc = exc;
		next_tx_d = tx_d;
		next_tx_v = 1'b0;
		next_tx_e = 1'b0;
		next_wr_valid = 1'b0;
		next_wr_num = wr_num;
		next_wr_data = wr_data;
		next_drop = 1'b0;
		crc_init = 1'b0;
		crc_v = 1'b0;
		crc_d = lnk.m2s_data;
		j = ptr - 8'(RD_HDR);
		ridx = RW'(fa) + RW'(j[7:1]);
		widx = RW'(fa) + RW'(ptr);
		di = BW'(WRN_HDR) + BW'({ptr, 1'b0});
		wdat = (fc == FC_WR1) ? fn : {rxb[di], rxb[di + BW'(1)]};
		// request checks, in the order a master expects them
		chk_bad = cnt < 9'(MIN_LEN) || crc != 16'h0000 || rxb[0] != own_addr;
		chk_exc = EXC_NONE;
		if (fc != FC_READ && fc != FC_WR1 && fc != FC_WRN) begin
			chk_exc = EXC_FUNC;
		end else if (fc == FC_WR1) begin
			if (cnt != 9'(REQ_LEN)) begin
				chk_exc = EXC_VAL;
			end else if (fa >= 16'(NREG)) begin
				chk_exc = EXC_ADDR;
			end
		end else if (fc == FC_READ) begin
			if (cnt != 9'(REQ_LEN) || fn == 16'h0000 || fn > 16'(MAX_RD_CNT)) begin
				chk_exc = EXC_VAL;
			end else if (fend > 17'(NREG)) begin
				chk_exc = EXC_ADDR;
			end
		end else if (cnt != wrn_len || fn == 16'h0000 || fn > 16'(MAX_WR_CNT)
			|| {fn[14:0], 1'b0} != {8'h00, rxb[6]}) begin
			chk_exc = EXC_VAL;
		end else if (fend > 17'(NREG)) begin
			chk_exc = EXC_ADDR;
		end
		if (chk_exc == EXC_NONE && dev_fail) begin
			chk_exc = EXC_FAIL;
		end
		// answer length without check sum
		if (exc != EXC_NONE) begin
			tx_len = 8'(EXC_LEN);
		end else if (fc == FC_READ) begin
			tx_len = 8'(RD_HDR) + {fn[6:0], 1'b0};
		end else begin
			tx_len = 8'(HDR_LEN);
		end
		// answer bytes; write answers copy the request head
		body = rxb[BW'(ptr)];
		case (ptr)
			8'h00: body = own_addr;
			8'h01: body = (exc != EXC_NONE) ? (fc | EXC_FLAG) : fc;
			8'h02: begin
				if (exc != EXC_NONE) begin
					body = exc;
				end else if (fc == FC_READ) begin
					body = {fn[6:0], 1'b0};
				end
			end
			default: ;
		endcase
		if (exc == EXC_NONE && fc == FC_READ && ptr >= 8'(RD_HDR)) begin
			body = j[0] ? regs[ridx][7:0] : regs[ridx][15:8];
		end
		case (state)
			ST_RX: begin
				if (lnk.m2s_valid) begin
					crc_v = 1'b1;
					crc_init = (cnt == 9'h000);
					if (cnt < 9'(MAXB)) begin
						next_rxb[BW'(cnt)] = lnk.m2s_data;
					end
					if (cnt != 9'h1FF) begin
						next_cnt = cnt + 9'h001;
					end
					if (lnk.m2s_eof) begin
						next_state = ST_CHK;
					end
				end
			end
			ST_CHK: begin
				next_cnt = 9'h000;
				next_ptr = 8'h00;
				next_exc = chk_exc;
				if (chk_bad) begin
					next_drop = 1'b1;
					next_state = ST_RX;
				end else if (chk_exc == EXC_NONE && fc != FC_READ) begin
					next_state = ST_WR;
				end else begin
					next_state = ST_TX;
				end
			end
			ST_WR: begin
				next_regs[widx] = wdat;
				next_wr_valid = 1'b1;
				next_wr_num = REG_NUM_BASE + 17'(fa) + 17'(ptr);
				next_wr_data = wdat;
				next_ptr = ptr + 8'h01;
				if (fc == FC_WR1 || {8'h00, ptr} == fn - 16'h0001) begin
					next_ptr = 8'h00;
					next_state = ST_TX;
				end
			end
			ST_TX: begin
				next_tx_v = 1'b1;
				next_ptr = ptr + 8'h01;
				if (ptr < tx_len) begin
					next_tx_d = body;
					crc_v = 1'b1;
					crc_d = body;
					crc_init = (ptr == 8'h00);
				end else if (ptr == tx_len) begin
					next_tx_d = crc[7:0];
				end else begin
					next_tx_d = crc[15:8];
					next_tx_e = 1'b1;
					next_ptr = 8'h00;
					next_state = ST_RX;
				end
			end
			default: next_state = ST_RX;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RX;
			for (int i = 0; i < MAXB; i++) begin
				rxb[i] <= 8'h00;
			end
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= REG_RST;
			end
			cnt <= 9'h000;
			ptr <= 8'h00;
			exc <= EXC_NONE;
			tx_d <= 8'h00;
			tx_v <= 1'b0;
			tx_e <= 1'b0;
			wr_valid <= 1'b0;
			wr_num <= 17'h00000;
			wr_data <= 16'h0000;
			drop <= 1'b0;
		end else begin
			state <= next_state;
			rxb <= next_rxb;
			regs <= next_regs;
			cnt <= next_cnt;
			ptr <= next_ptr;
			exc <= next_exc;
			tx_d <= next_tx_d;
			tx_v <= next_tx_v;
			tx_e <= next_tx_e;
			wr_valid <= next_wr_valid;
			wr_num <= next_wr_num;
			wr_data <= next_wr_data;
			drop <= next_drop;
		end
	end
endmodule

`default_nettype wire

// ### verilog/mrs_master.sv
/*
 * master end: sends one request, collects and checks the answer
 * assumes a single slave answers at a time; read words are passed on
 * as they arrive, before the closing check sum is known
 */
`default_nettype none

module mrs_master #(
	parameter int NW = 4,
	parameter int TMO = 50000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link to the slave
	mrs_link_if.master lnk,
	// request
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_slave,
	input wire logic [7:0] cmd_fc,
	input wire mrs_pkg::mrs_word_t cmd_addr,
	input wire mrs_pkg::mrs_word_t cmd_count,
	input wire mrs_pkg::mrs_word_t cmd_words [NW],
	output logic cmd_ready,
	// answer
	output logic rsp_done,
	output logic [7:0] rsp_exc,
	output logic rsp_crc_err,
	output logic rsp_timeout,
	output logic rd_valid,
	output mrs_pkg::mrs_word_t rd_data
);
	import mrs_pkg::*;

	localparam int TW = $clog2(TMO + 1);
	localparam int NWB = $clog2(NW);

	if (NW < 2 || NW > MAX_WR_CNT || TMO < 2) begin : g_bad_par
		$error("NW or TMO out of range");
	end

	mrs_host_st_t state, next_state;
	logic [7:0] q_slave, q_fc, next_q_slave, next_q_fc;
	mrs_word_t q_addr, q_cnt, next_q_addr, next_q_cnt;
	mrs_word_t q_words [NW];
	mrs_word_t next_q_words [NW];
	logic [7:0] ptr, next_ptr, rx_fc, next_rx_fc, rx_b2, next_rx_b2, rx_hi, next_rx_hi;
	logic [TW-1:0] tmr, next_tmr;
	logic [7:0] tx_d, next_tx_d, tx_len, body, k, next_rsp_exc;
	logic tx_v, next_tx_v, tx_e, next_tx_e, next_cmd_ready;
	logic next_rsp_done, next_rsp_crc_err, next_rsp_timeout, next_rd_valid;
	mrs_word_t next_rd_data, word;
	logic crc_init, crc_v;
	logic [7:0] crc_d;
	mrs_word_t crc;

	assign lnk.m2s_data = tx_d;
	assign lnk.m2s_valid = tx_v;
	assign lnk.m2s_eof = tx_e;

	mrs_crc u_crc (
		.clk(clk),
		.rst_n(rst_n),
		.init(crc_init),
		.valid(crc_v),
		.data(crc_d),
		.crc(crc)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		{next_q_slave, next_q_fc, next_q_addr, next_q_cnt} = {q_slave, q_fc, q_addr, q_cnt};
		next_q_words = q_words;
		{next_ptr, next_rx_fc, next_rx_b2, next_rx_hi} = {ptr, rx_fc, rx_b2, rx_hi};
		next_tmr = tmr;
		next_tx_d = tx_d;
		{next_tx_v, next_tx_e, next_rsp_done, next_rd_valid} = 4'h0;
		next_rsp_exc = rsp_exc;
		next_rsp_crc_err = rsp_crc_err;
		next_rsp_timeout = rsp_timeout;
		next_rd_data = rd_data;
		crc_init = 1'b0;
		crc_v = 1'b0;
		crc_d = lnk.s2m_data;
		tx_len = (q_fc == FC_WRN) ? 8'(WRN_HDR) + {q_cnt[6:0], 1'b0} : 8'(HDR_LEN);
		k = ptr - 8'(WRN_HDR);
		word = q_words[NWB'(k[7:1])];
		case (ptr)
			8'h00: body = q_slave;
			8'h01: body = q_fc;
			8'h02: body = q_addr[15:8];
			8'h03: body = q_addr[7:0];
			8'h04: body = q_cnt[15:8];
			8'h05: body = q_cnt[7:0];
			8'h06: body = {q_cnt[6:0], 1'b0};
			default: body = k[0] ? word[7:0] : word[15:8];
		endcase
		case (state)
			HS_IDLE: begin
				if (cmd_valid) begin
					{next_q_slave, next_q_fc} = {cmd_slave, cmd_fc};
					{next_q_addr, next_q_cnt} = {cmd_addr, cmd_count};
					next_q_words = cmd_words;
					next_ptr = 8'h00;
					next_state = HS_TX;
				end
			end
			HS_TX: begin
				next_tx_v = 1'b1;
				next_ptr = ptr + 8'h01;
				if (ptr < tx_len) begin
					next_tx_d = body;
					crc_v = 1'b1;
					crc_d = body;
					crc_init = (ptr == 8'h00);
				end else if (ptr == tx_len) begin
					next_tx_d = crc[7:0];
				end else begin
					next_tx_d = crc[15:8];
					next_tx_e = 1'b1;
					next_ptr = 8'h00;
					next_tmr = '0;
					next_state = HS_RX;
				end
			end
			HS_RX: begin
				next_tmr = tmr + TW'(1);
				if (lnk.s2m_valid) begin
					crc_v = 1'b1;
					crc_init = (ptr == 8'h00);
					next_tmr = '0;
					next_ptr = ptr + 8'h01;
					if (ptr == 8'h01) next_rx_fc = lnk.s2m_data;
					if (ptr == 8'h02) next_rx_b2 = lnk.s2m_data;
					if (ptr >= 8'h03 && ptr[0]) next_rx_hi = lnk.s2m_data;
					if (rx_fc == FC_READ && ptr >= 8'h04 && !ptr[0]
						&& {8'h00, ptr} <= 16'h0002 + {q_cnt[14:0], 1'b0}) begin
						next_rd_valid = 1'b1;
						next_rd_data = {rx_hi, lnk.s2m_data};
					end
					if (lnk.s2m_eof) next_state = HS_END;
				end else if (tmr == TW'(TMO - 1)) begin
					next_rsp_done = 1'b1;
					next_rsp_timeout = 1'b1;
					next_rsp_crc_err = 1'b0;
					next_rsp_exc = EXC_NONE;
					next_state = HS_IDLE;
				end
			end
			HS_END: begin
				next_rsp_done = 1'b1;
				next_rsp_timeout = 1'b0;
				next_rsp_crc_err = (crc != 16'h0000);
				next_rsp_exc = rx_fc[7] ? rx_b2 : EXC_NONE;
				next_state = HS_IDLE;
			end
			default: next_state = HS_IDLE;
		endcase
		next_cmd_ready = (next_state == HS_IDLE);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= HS_IDLE;
			{q_slave, q_fc, q_addr, q_cnt} <= 48'h0;
			for (int i = 0; i < NW; i++) begin
				q_words[i] <= 16'h0000;
			end
			{ptr, rx_fc, rx_b2, rx_hi} <= 32'h0;
			tmr <= '0;
			tx_d <= 8'h00;
			{tx_v, tx_e, rsp_done, rd_valid, rsp_crc_err, rsp_timeout} <= 6'h00;
			cmd_ready <= 1'b1;
			rsp_exc <= 8'h00;
			rd_data <= 16'h0000;
		end else begin
			state <= next_state;
			{q_slave, q_fc, q_addr, q_cnt} <= {next_q_slave, next_q_fc, next_q_addr, next_q_cnt};
			q_words <= next_q_words;
			{ptr, rx_fc, rx_b2, rx_hi} <= {next_ptr, next_rx_fc, next_rx_b2, next_rx_hi};
			tmr <= next_tmr;
			tx_d <= next_tx_d;
			tx_v <= next_tx_v;
			tx_e <= next_tx_e;
			rsp_done <= next_rsp_done;
			rd_valid <= next_rd_valid;
			rsp_crc_err <= next_rsp_crc_err;
			rsp_timeout <= next_rsp_timeout;
			cmd_ready <= next_cmd_ready;
			rsp_exc <= next_rsp_exc;
			rd_data <= next_rd_data;
		end
	end
endmodule

`default_nettype wire

// ### verification/mrs_link_chk.sv
/*
 * checker on the byte link between master end and slave end
 * assumes one clock and one async low reset for both ends
 */
`default_nettype none

module mrs_link_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// station address of the slave
	input wire logic [7:0] own_addr,
	// link signals
	input wire logic [7:0] m2s_data,
	input wire logic m2s_valid,
	input wire logic m2s_eof,
	input wire logic [7:0] s2m_data,
	input wire logic s2m_valid,
	input wire logic s2m_eof
);
	import mrs_pkg::*;
	// ----------------------------------------
	// frame trackers
	// ----------------------------------------
	logic [7:0] si, mi, s_code, s_bc, rq_cnt;
	logic [15:0] s_crc, m_crc, s_res, m_res;
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		return c;
	endfunction
	// residue over a whole frame including its check sum is zero
	assign s_res = crc_upd(s_crc, s2m_data);
	assign m_res = crc_upd(m_crc, m2s_data);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			si <= 8'h00;
			mi <= 8'h00;
			s_code <= 8'h00;
			s_bc <= 8'h00;
			rq_cnt <= 8'h00;
			s_crc <= 16'hFFFF;
			m_crc <= 16'hFFFF;
		end else begin
			if (s2m_valid) begin
				si <= s2m_eof ? 8'h00 : si + 8'h01;
				s_crc <= s2m_eof ? 16'hFFFF : s_res;
				if (si == 8'h01) s_code <= s2m_data;
				if (si == 8'h02) s_bc <= s2m_data;
			end
			if (m2s_valid) begin
				mi <= m2s_eof ? 8'h00 : mi + 8'h01;
				m_crc <= m2s_eof ? 16'hFFFF : m_res;
				if (mi == 8'h05) rq_cnt <= m2s_data;
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence exc_head;
		s2m_valid && si == 8'h01 && s2m_data[7];
	endsequence
	sequence exc_tail;
		s2m_valid ##1 s2m_valid ##1 (s2m_valid && s2m_eof);
	endsequence
	a_req_framing: assert property (m2s_eof |-> m2s_valid)
		else $error("request end without byte");
	a_ans_framing: assert property (s2m_eof |-> s2m_valid)
		else $error("answer end without byte");
	a_reply_station: assert property (s2m_valid && si == 8'h00 |-> s2m_data == own_addr)
		else $error("answer does not start with station");
	a_reply_crc: assert property (s2m_valid && s2m_eof |-> s_res == 16'h0000)
		else $error("answer check sum wrong");
	a_request_crc: assert property (m2s_valid && m2s_eof |-> m_res == 16'h0000)
		else $error("request check sum wrong");
	a_answer_burst: assert property (s2m_valid && !s2m_eof |=> s2m_valid)
		else $error("gap inside answer");
	a_exc_code: assert property (exc_head |=> s2m_data inside {[8'h01:8'h04]})
		else $error("exception code out of range");
	a_exc_length: assert property (exc_head |=> exc_tail)
		else $error("exception answer not five bytes");
	a_read_count: assert property (s2m_valid && si == 8'h02 && s_code == FC_READ
		|-> s2m_data == {rq_cnt[6:0], 1'b0})
		else $error("read byte count wrong");
	a_read_length: assert property (s2m_eof && s_code == FC_READ |-> si == s_bc + 8'h04)
		else $error("read answer length wrong");
	a_wrn_length: assert property (s2m_eof && s_code == FC_WRN |-> si == 8'h07)
		else $error("multi write answer length wrong");
	a_wr1_length: assert property (s2m_eof && s_code == FC_WR1 |-> si == 8'h07)
		else $error("single write answer length wrong");
endmodule

`default_nettype wire

// ### verification/mrs_modbus_rtu_slave_frame_crc_bench.sv
/*
 * bench: master end and slave end on one link, second slave on a bench-driven link
 * assumes package, interface, design ends and checker compiled before
 */
`default_nettype none

module mrs_modbus_rtu_slave_frame_crc_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import mrs_pkg::*;
	typedef struct {logic [7:0] fc; mrs_word_t a; mrs_word_t n; logic [7:0] exc; mrs_word_t crc;} mrs_row_t;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0, rst_n = 1'b0, dev_fail = 1'b0, cmd_valid = 1'b0;
	logic [7:0] own_addr = 8'h01, cmd_slave = 8'h01, cmd_fc = 8'h00, rsp_exc;
	mrs_word_t cmd_addr = 16'h0000, cmd_count = 16'h0000, wr_data, rd_data;
	mrs_word_t cw [4] = '{16'h0064, 16'h0064, 16'h0258, 16'h01F4};
	mrs_word_t mdl [16] = '{default: REG_RST};
	logic wr_valid, drop, drop2, cmd_ready, rsp_done, rsp_crc_err, rsp_timeout, rd_valid;
	mrs_regnum_t wr_num;
	int n_mismatch = 0, num_checks = 0, n_drop = 0, n_drop2 = 0, n_s2 = 0;
	logic [7:0] mq [$], sq [$];
	mrs_word_t rdq [$];
	logic [32:0] wq [$];
	// zero in crc column: request check sum not compared
	mrs_row_t rows [12] = '{
		'{FC_READ, 16'h0000, 16'h0005, EXC_NONE, 16'h85C9},
		'{FC_WRN, 16'h0004, 16'h0004, EXC_NONE, 16'h0000},
		'{FC_READ, 16'h0004, 16'h0004, EXC_NONE, 16'h0000},
		'{FC_WR1, 16'h000F, 16'hFFFF, EXC_NONE, 16'h0000},
		'{FC_READ, 16'h000C, 16'h0004, EXC_NONE, 16'h0000},
		'{8'h05, 16'h0000, 16'h0001, EXC_FUNC, 16'h0000},
		'{FC_READ, 16'h0000, 16'h0000, EXC_VAL, 16'h0000},
		'{FC_READ, 16'h0000, 16'h007E, EXC_VAL, 16'h0000},
		'{FC_READ, 16'h0000, 16'h007D, EXC_ADDR, 16'h0000},
		'{FC_READ, 16'h000E, 16'h0003, EXC_ADDR, 16'h0000},
		'{FC_WR1, 16'h0010, 16'h1234, EXC_ADDR, 16'h0000},
		'{FC_WRN, 16'h004B, 16'h0004, EXC_ADDR, 16'h86EC}};
	mrs_link_if lk();
	mrs_link_if lk2();
	always #10 clk = ~clk;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	mrs_master #(.NW(4), .TMO(64)) mrs_master_i (.clk(clk), .rst_n(rst_n), .lnk(lk),
		.cmd_valid(cmd_valid), .cmd_slave(cmd_slave), .cmd_fc(cmd_fc), .cmd_addr(cmd_addr),
		.cmd_count(cmd_count), .cmd_words(cw), .cmd_ready(cmd_ready), .rsp_done(rsp_done),
		.rsp_exc(rsp_exc), .rsp_crc_err(rsp_crc_err), .rsp_timeout(rsp_timeout),
		.rd_valid(rd_valid), .rd_data(rd_data));
	mrs_slave #(.NREG(16)) mrs_slave_i (.clk(clk), .rst_n(rst_n), .lnk(lk), .own_addr(own_addr),
		.dev_fail(dev_fail), .wr_valid(wr_valid), .wr_num(wr_num), .wr_data(wr_data), .drop(drop));
	mrs_slave #(.NREG(16)) mrs_slave_i2 (.clk(clk), .rst_n(rst_n), .lnk(lk2), .own_addr(own_addr),
		.dev_fail(1'b0), .wr_valid(), .wr_num(), .wr_data(), .drop(drop2));
	mrs_link_chk mrs_link_chk_i (.clk(clk), .rst_n(rst_n), .own_addr(own_addr),
		.m2s_data(lk.m2s_data), .m2s_valid(lk.m2s_valid), .m2s_eof(lk.m2s_eof),
		.s2m_data(lk.s2m_data), .s2m_valid(lk.s2m_valid), .s2m_eof(lk.s2m_eof));
	// ----------------------------------------
	// monitors and tasks
	// ----------------------------------------
	always @(negedge clk) begin
		if (lk.m2s_valid === 1'b1) mq.push_back(lk.m2s_data);
		if (lk.s2m_valid === 1'b1) sq.push_back(lk.s2m_data);
		if (rd_valid === 1'b1) rdq.push_back(rd_data);
		if (wr_valid === 1'b1) wq.push_back({wr_num, wr_data});
		if (drop === 1'b1) n_drop++;
		if (drop2 === 1'b1) n_drop2++;
		if (lk2.s2m_valid === 1'b1) n_s2++;
	end
	task automatic chk_v(input string nm, input logic [32:0] e, input logic [32:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic run_cmd(input mrs_row_t r, input logic to);
		int k;
		mq = {};
		sq = {};
		rdq = {};
		wq = {};
		cmd_fc = r.fc;
		cmd_addr = r.a;
		cmd_count = r.n;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (k = 0; k < 400 && rsp_done !== 1'b1; k++) @(negedge clk);
		if (k == 400) begin
			n_mismatch++;
			complete_run();
		end
		chk_v("timeout", 33'(to), 33'(rsp_timeout));
		chk_v("crc error", 33'h0, 33'(rsp_crc_err));
		if (!to) chk_v("exception", 33'(r.exc), 33'(rsp_exc));
		if (r.crc != 16'h0000) chk_v("req crc", 33'(r.crc), 33'({mq[$-1], mq[$]}));
		if (r.exc != EXC_NONE) begin
			chk_v("exc size", 33'd5, 33'(sq.size()));
			chk_v("exc fc", 33'(r.fc | EXC_FLAG), 33'(sq[1]));
		end else if (!to) case (r.fc)
			FC_READ: begin
				chk_v("read count", 33'(r.n), 33'(rdq.size()));
				foreach (rdq[i]) chk_v("read word", 33'(mdl[r.a + i]), 33'(rdq[i]));
			end
			FC_WR1: begin
				mdl[r.a] = r.n;
				chk_v("write", {17'(REG_NUM_BASE + r.a), r.n}, wq[0]);
				chk_v("echo size", 33'(mq.size()), 33'(sq.size()));
				foreach (sq[i]) chk_v("echo", 33'(mq[i]), 33'(sq[i]));
			end
			default: begin
				chk_v("writes", 33'(r.n), 33'(wq.size()));
				chk_v("answer size", 33'd8, 33'(sq.size()));
				foreach (wq[i]) begin
					mdl[r.a + i] = cw[i];
					chk_v("write", {17'(REG_NUM_BASE + r.a + i), cw[i]}, wq[i]);
				end
			end
		endcase
	endtask
	// eight request bytes on the second link, first byte in the top bits
	task automatic send2(input logic [63:0] f);
		for (int i = 7; i >= 0; i--) begin
			lk2.m2s_data = f[i*8 +: 8];
			lk2.m2s_valid = 1'b1;
			lk2.m2s_eof = (i == 0);
			@(negedge clk);
		end
		lk2.m2s_valid = 1'b0;
		lk2.m2s_eof = 1'b0;
		// released line must not keep the last byte
		lk2.m2s_data = ~lk2.m2s_data;
		repeat (30) @(negedge clk);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		lk2.m2s_data = 8'h00;
		lk2.m2s_valid = 1'b0;
		lk2.m2s_eof = 1'b0;
		repeat (6) @(negedge clk);
		chk_v("ready in reset", 33'h1, 33'(cmd_ready));
		chk_v("link in reset", 33'h0, 33'(lk.s2m_valid));
		rst_n = 1'b1;
		@(negedge clk);
		foreach (rows[i]) run_cmd(rows[i], 1'b0);
		dev_fail = 1'b1;
		run_cmd(mrs_row_t'{FC_READ, 16'h0000, 16'h0001, EXC_FAIL, 16'h0000}, 1'b0);
		dev_fail = 1'b0;
		cmd_slave = 8'h02;
		run_cmd(mrs_row_t'{FC_READ, 16'h0000, 16'h0001, EXC_NONE, 16'h0000}, 1'b1);
		chk_v("drops", 33'h1, 33'(n_drop));
		chk_v("silent", 33'h0, 33'(sq.size()));
		send2(64'h010300000005_85C8);
		chk_v("bad crc drop", 33'h1, 33'(n_drop2));
		chk_v("bad crc silent", 33'h0, 33'(n_s2));
		send2(64'h010300000005_85C9);
		chk_v("good crc answer", 33'd15, 33'(n_s2));
		complete_run();
	end
endmodule

`default_nettype wire
